// *** pkg/kmsc_pkg.sv ***
// constants, types and register map of the keyboard and pointer link controller
// assumes a 10 MHz system clock and word-aligned AXI4-Lite register access
package kmsc_pkg;
  localparam int KMSC_NCH = 2;
  localparam int KMSC_RW = 8;
  // register indices as printed; byte address is four times the index
  localparam logic [31:0] KMSC_KBD_CONTROL_IDX = 32'h1100_0500;
  localparam logic [31:0] KMSC_KBD_STATUS_IDX = 32'h1100_0502;
  localparam logic [31:0] KMSC_KBD_TRANSMIT_BYTE_IDX = 32'h1100_0504;
  localparam logic [31:0] KMSC_KBD_RECEIVE_BYTE_IDX = 32'h1100_0506;
  localparam logic [31:0] KMSC_MOUSE_CONTROL_IDX = 32'h1100_0508;
  localparam logic [31:0] KMSC_MOUSE_STATUS_IDX = 32'h1100_050a;
  localparam logic [31:0] KMSC_MOUSE_TRANSMIT_BYTE_IDX = 32'h1100_050c;
  localparam logic [31:0] KMSC_MOUSE_RECEIVE_BYTE_IDX = 32'h1100_050e;
  localparam logic [KMSC_NCH-1:0][3:0][31:0] KMSC_REG_IDX = {
    {KMSC_MOUSE_RECEIVE_BYTE_IDX, KMSC_MOUSE_TRANSMIT_BYTE_IDX, KMSC_MOUSE_STATUS_IDX, KMSC_MOUSE_CONTROL_IDX},
    {KMSC_KBD_RECEIVE_BYTE_IDX, KMSC_KBD_TRANSMIT_BYTE_IDX, KMSC_KBD_STATUS_IDX, KMSC_KBD_CONTROL_IDX}};
  localparam logic [1:0] KMSC_SEL_CTRL = 2'h0;
  localparam logic [1:0] KMSC_SEL_STAT = 2'h1;
  localparam logic [1:0] KMSC_SEL_TX = 2'h2;
  localparam logic [1:0] KMSC_SEL_RX = 2'h3;
  // control bits
  localparam int KMSC_CTL_RUN = 0;
  localparam int KMSC_CTL_CLK_REL = 2;
  localparam int KMSC_CTL_DAT_REL = 3;
  localparam int KMSC_CTL_RXIE = 4;
  localparam int KMSC_CTL_TXIE = 5;
  localparam logic [KMSC_RW-1:0] KMSC_CTL_RESET = 8'h00;
  // status bits
  localparam int KMSC_ST_RX_DONE = 2;
  localparam int KMSC_ST_TX_DONE = 3;
  // frame shape
  localparam logic [3:0] KMSC_RX_LAST_EDGE = 4'ha;
  localparam logic [3:0] KMSC_TX_BITS = 4'ha;
  // request hold time
  localparam int KMSC_CLK_PERIOD_NS = 100;
  localparam int KMSC_REQ_HOLD_US = 48;
  localparam int KMSC_REQ_HOLD_CYC = (KMSC_REQ_HOLD_US * 1000 + KMSC_CLK_PERIOD_NS - 1) / KMSC_CLK_PERIOD_NS;
  localparam int KMSC_TMR_W = 10;
  // bus answers
  localparam logic [1:0] KMSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] KMSC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KMSC_IDLE,
    KMSC_RX,
    KMSC_TX_CLKLOW,
    KMSC_TX_START,
    KMSC_TX_SHIFT
  } kmsc_state_t;
endpackage

// *** pkg/kmsc_pin_if.sv ***
// synchronised view of one link's clock and data line
// driven by the pin synchroniser, read by the link logic
`timescale 1ns/1ps
`default_nettype none
interface kmsc_pin_if;
  logic clk_level;
  logic dat_level;
  logic clk_fall;
  modport src (output clk_level, output dat_level, output clk_fall);
  modport dst (input clk_level, input dat_level, input clk_fall);
endinterface
`default_nettype wire

// *** rtl/kmsc_pin_sync.sv ***
// two-stage synchroniser for a link clock and data pin, with falling-edge detect
// pins are asynchronous; idle level of both lines is high
`timescale 1ns/1ps
`default_nettype none
module kmsc_pin_sync
  import kmsc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins
  input wire logic link_clock_pin,
  input wire logic link_line_pin,
  // synchronised view
  kmsc_pin_if.src view
);
  typedef struct packed {
    logic [1:0] clk_ff;
    logic [1:0] dat_ff;
    logic clk_prev;
  } kmsc_sync_t;

  localparam kmsc_sync_t SYNC_RESET = '1;

  kmsc_sync_t r;
  kmsc_sync_t next_r;

  always_comb
  begin
    next_r.clk_ff = {r.clk_ff[0], link_clock_pin};
    next_r.dat_ff = {r.dat_ff[0], link_line_pin};
    next_r.clk_prev = r.clk_ff[1];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= SYNC_RESET;
    else
      r <= next_r;
  end

  assign view.clk_level = r.clk_ff[1];
  assign view.dat_level = r.dat_ff[1];
  assign view.clk_fall = r.clk_prev & ~r.clk_ff[1];
endmodule
`default_nettype wire

// *** rtl/kmsc_hold_timer.sv ***
// one-shot timer for the send-request hold phases
// start reloads it; expired pulses one cycle, the hold time after start
`timescale 1ns/1ps
`default_nettype none
module kmsc_hold_timer
  import kmsc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  output logic expired
);
  typedef struct packed {
    logic [KMSC_TMR_W-1:0] count;
    logic run;
  } kmsc_tmr_t;

  localparam kmsc_tmr_t TMR_RESET = '0;
  localparam logic [KMSC_TMR_W-1:0] TMR_LOAD = KMSC_TMR_W'(KMSC_REQ_HOLD_CYC - 1);

  kmsc_tmr_t r;
  kmsc_tmr_t next_r;

  always_comb
  begin
    next_r = r;
    if (start)
    begin
      next_r.count = TMR_LOAD;
      next_r.run = 1'b1;
    end
    else if (r.run)
    begin
      if (r.count == '0)
        next_r.run = 1'b0;
      else
        next_r.count = r.count - 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= TMR_RESET;
    else
      r <= next_r;
  end

  assign expired = r.run && (r.count == '0);
endmodule
`default_nettype wire

// *** rtl/kmsc_top.sv ***
// keyboard and pointer serial link controller with AXI4-Lite register slave
// assumes open-drain link pins pulled up outside; the peripheral drives the link clock
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module kmsc_top
  import kmsc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  // axi4-lite write response
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  // axi4-lite read data
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // keyboard link pins
  input wire logic key_link_clock_i,
  output logic key_link_clock_o,
  output logic key_link_clock_oe,
  input wire logic key_link_line_i,
  output logic key_link_line_o,
  output logic key_link_line_oe,
  // pointer link pins
  input wire logic pointer_link_clock_i,
  output logic pointer_link_clock_o,
  output logic pointer_link_clock_oe,
  input wire logic pointer_link_line_i,
  output logic pointer_link_line_o,
  output logic pointer_link_line_oe,
  // interrupts
  output logic key_irq,
  output logic pointer_irq
);
  typedef struct packed {
    logic [KMSC_RW-1:0] ctl;
    kmsc_state_t state;
    logic [3:0] edges;
    logic [9:0] sreg;
    logic [9:0] tx_frame;
    logic tx_line;
    logic [KMSC_RW-1:0] rx_byte;
    logic rx_done;
    logic tx_done;
    logic tx_busy;
    logic perr;
  } kmsc_chan_t;

  typedef struct packed {
    logic aw_full;
    logic w_full;
    logic [31:0] awaddr;
    logic [KMSC_RW-1:0] wbyte;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [KMSC_RW-1:0] rbyte;
    logic [1:0] rresp;
    kmsc_chan_t [KMSC_NCH-1:0] ch;
  } kmsc_top_t;

  // control 00h keeps the link in reset with both lines forced low
  localparam kmsc_top_t TOP_RESET = '0;

  kmsc_top_t r;
  kmsc_top_t next_r;
  kmsc_chan_t next_ch [KMSC_NCH];

  logic [KMSC_NCH-1:0] clk_pin;
  logic [KMSC_NCH-1:0] dat_pin;
  logic [KMSC_NCH-1:0] clk_oe;
  logic [KMSC_NCH-1:0] dat_oe;
  logic [KMSC_NCH-1:0] irq;
  logic tmr_start [KMSC_NCH];
  logic [KMSC_NCH-1:0] tmr_exp;
  logic wr_fire;
  logic rd_fire;
  logic [3:0] wr_dec;
  logic [3:0] rd_dec;
  logic [KMSC_RW-1:0] rd_byte;

  // returns {hit, channel, register select}
  function automatic logic [3:0] kmsc_decode(input logic [31:0] a);
    logic [3:0] d;
    d = 4'h0;
    for (int c = 0; c < KMSC_NCH; c++)
    begin
      for (int s = 0; s < 4; s++)
      begin
        if (a[31:2] == KMSC_REG_IDX[c][s][29:0])
          d = {1'b1, 1'(c), 2'(s)};
      end
    end
    return d;
  endfunction

  assign clk_pin = {pointer_link_clock_i, key_link_clock_i};
  assign dat_pin = {pointer_link_line_i, key_link_line_i};

  // bus handshakes
  assign s_axil_awready = !r.aw_full && !r.bvalid;
  assign s_axil_wready = !r.w_full && !r.bvalid;
  assign s_axil_arready = !r.rvalid;
  assign wr_fire = r.aw_full && r.w_full && !r.bvalid;
  assign rd_fire = s_axil_arvalid && s_axil_arready;
  assign wr_dec = kmsc_decode(r.awaddr);
  assign rd_dec = kmsc_decode(s_axil_araddr);

  // read mux; the transmit byte is write-only and reads zero
  always_comb
  begin
    kmsc_chan_t c;
    c = r.ch[rd_dec[2]];
    rd_byte = '0;
    if (rd_dec[3])
    begin
      unique case (rd_dec[1:0])
        KMSC_SEL_CTRL: rd_byte = c.ctl;
        KMSC_SEL_STAT: rd_byte = {3'h0, c.perr, c.tx_done, c.rx_done, c.tx_busy, c.state == KMSC_RX};
        KMSC_SEL_TX: rd_byte = '0;
        KMSC_SEL_RX: rd_byte = c.rx_byte;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < KMSC_NCH; gi++)
    begin : g_ch
      kmsc_pin_if view ();
      logic w_ctl;
      logic w_st;
      logic w_tx;

      kmsc_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .link_clock_pin(clk_pin[gi]),
        .link_line_pin(dat_pin[gi]),
        .view(view.src)
      );

      kmsc_hold_timer u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(tmr_start[gi]),
        .expired(tmr_exp[gi])
      );

      // one register set per channel
      assign w_ctl = wr_fire && r.wstrb0 && wr_dec[3] && (wr_dec[2] == 1'(gi)) && (wr_dec[1:0] == KMSC_SEL_CTRL);
      assign w_st = wr_fire && r.wstrb0 && wr_dec[3] && (wr_dec[2] == 1'(gi)) && (wr_dec[1:0] == KMSC_SEL_STAT);
      assign w_tx = wr_fire && r.wstrb0 && wr_dec[3] && (wr_dec[2] == 1'(gi)) && (wr_dec[1:0] == KMSC_SEL_TX);

      always_comb
      begin
        kmsc_chan_t c;
        kmsc_chan_t n;
        c = r.ch[gi];
        n = c;
        tmr_start[gi] = 1'b0;
        if (w_ctl)
          n.ctl = r.wbyte;
        if (!c.ctl[KMSC_CTL_RUN])
        begin
          // link held in reset, frame aborted
          n.state = KMSC_IDLE;
          n.edges = '0;
          n.tx_line = 1'b1;
          n.rx_done = 1'b0;
          n.tx_done = 1'b0;
          n.tx_busy = 1'b0;
          n.perr = 1'b0;
        end
        else
        begin
          // clears first so a same-cycle set below wins
          if (w_st && !r.wbyte[KMSC_ST_RX_DONE])
            n.rx_done = 1'b0;
          if (w_st && !r.wbyte[KMSC_ST_TX_DONE])
            n.tx_done = 1'b0;
          if (w_tx && !c.tx_busy)
          begin
            n.tx_busy = 1'b1;
            n.tx_frame = {1'b1, ~^r.wbyte, r.wbyte};
          end
          unique case (c.state)
            KMSC_IDLE:
            begin
              if (view.clk_fall && !view.dat_level && !c.rx_done)
              begin
                n.state = KMSC_RX;
                n.edges = 4'h1;
              end
              else if (c.tx_busy && view.dat_level && !c.rx_done)
              begin
                n.state = KMSC_TX_CLKLOW;
                n.sreg = c.tx_frame;
                tmr_start[gi] = 1'b1;
              end
            end
            KMSC_RX:
            begin
              if (view.clk_fall)
              begin
                if (c.edges == KMSC_RX_LAST_EDGE)
                begin
                  // stop bit is not checked
                  n.state = KMSC_IDLE;
                  n.rx_done = 1'b1;
                  n.rx_byte = c.sreg[8:1];
                  n.perr = ~^c.sreg[9:1];
                end
                else
                begin
                  n.sreg = {view.dat_level, c.sreg[9:1]};
                  n.edges = c.edges + 1'b1;
                end
              end
            end
            KMSC_TX_CLKLOW:
            begin
              if (tmr_exp[gi])
              begin
                n.state = KMSC_TX_START;
                tmr_start[gi] = 1'b1;
              end
            end
            KMSC_TX_START:
            begin
              if (tmr_exp[gi])
              begin
                n.state = KMSC_TX_SHIFT;
                n.edges = '0;
                n.tx_line = 1'b0;
              end
            end
            KMSC_TX_SHIFT:
            begin
              if (view.clk_fall)
              begin
                if (c.edges == KMSC_TX_BITS)
                begin
                  n.state = KMSC_IDLE;
                  n.tx_done = 1'b1;
                  n.tx_busy = 1'b0;
                  n.tx_line = 1'b1;
                end
                else
                begin
                  n.tx_line = c.sreg[0];
                  n.sreg = {1'b1, c.sreg[9:1]};
                  n.edges = c.edges + 1'b1;
                end
              end
            end
          endcase
        end
        next_ch[gi] = n;
      end

      // open-drain drive: enable pulls the line low
      assign clk_oe[gi] = !r.ch[gi].ctl[KMSC_CTL_CLK_REL]
        || r.ch[gi].rx_done
        || (r.ch[gi].state == KMSC_TX_CLKLOW) || (r.ch[gi].state == KMSC_TX_START);
      assign dat_oe[gi] = !r.ch[gi].ctl[KMSC_CTL_DAT_REL]
        || (r.ch[gi].state == KMSC_TX_START)
        || ((r.ch[gi].state == KMSC_TX_SHIFT) && !r.ch[gi].tx_line);
      assign irq[gi] = (r.ch[gi].rx_done && r.ch[gi].ctl[KMSC_CTL_RXIE])
        || (r.ch[gi].tx_done && r.ch[gi].ctl[KMSC_CTL_TXIE]);
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    for (int k = 0; k < KMSC_NCH; k++)
      next_r.ch[k] = next_ch[k];
    if (s_axil_awvalid && s_axil_awready)
    begin
      next_r.aw_full = 1'b1;
      next_r.awaddr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready)
    begin
      next_r.w_full = 1'b1;
      next_r.wbyte = s_axil_wdata[KMSC_RW-1:0];
      next_r.wstrb0 = s_axil_wstrb[0];
    end
    if (wr_fire)
    begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = wr_dec[3] ? KMSC_RESP_OKAY : KMSC_RESP_SLVERR;
    end
    else if (r.bvalid && s_axil_bready)
      next_r.bvalid = 1'b0;
    if (rd_fire)
    begin
      next_r.rvalid = 1'b1;
      next_r.rbyte = rd_byte;
      next_r.rresp = rd_dec[3] ? KMSC_RESP_OKAY : KMSC_RESP_SLVERR;
    end
    else if (r.rvalid && s_axil_rready)
      next_r.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      r <= TOP_RESET;
    else
      r <= next_r;
  end

  assign s_axil_bresp = r.bresp;
  assign s_axil_bvalid = r.bvalid;
  assign s_axil_rdata = {24'h00_0000, r.rbyte};
  assign s_axil_rresp = r.rresp;
  assign s_axil_rvalid = r.rvalid;

  assign {key_link_clock_o, key_link_line_o, pointer_link_clock_o, pointer_link_line_o} = 4'h0;
  assign key_link_clock_oe = clk_oe[0];
  assign key_link_line_oe = dat_oe[0];
  assign pointer_link_clock_oe = clk_oe[1];
  assign pointer_link_line_oe = dat_oe[1];
  assign key_irq = irq[0];
  assign pointer_irq = irq[1];
endmodule
`default_nettype wire

// *** dv/kmsc_sva.sv ***
// assertions on the ports of the link controller, keyboard channel and bus
// bound to kmsc_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module kmsc_sva
  import kmsc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [31:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  // keyboard link
  input wire logic key_link_clock_oe,
  input wire logic key_link_line_oe,
  input wire logic key_irq
);
  logic [31:0] aa;
  logic [7:0] wd;
  logic [7:0] kctl;
  logic [7:0] kc;
  logic ws;
  logic pb;
  logic [9:0] c1;
  logic [9:0] c2;
  // control shadow; kc shows a write in the cycle it takes effect
  assign kc = (s_axil_bvalid && !pb && ws && aa == {KMSC_KBD_CONTROL_IDX[29:0], 2'b00}) ? wd : kctl;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      kctl <= 8'h00;
      pb <= 1'h0;
      c1 <= 10'h000;
      c2 <= 10'h000;
    end
    else
    begin
      if (s_axil_awvalid && s_axil_awready)
        aa <= s_axil_awaddr;
      if (s_axil_wvalid && s_axil_wready)
      begin
        wd <= s_axil_wdata[7:0];
        ws <= s_axil_wstrb[0];
      end
      kctl <= kc;
      pb <= s_axil_bvalid;
      c1 <= (key_link_clock_oe && !key_link_line_oe) ? c1 + 10'h001 : 10'h000;
      c2 <= (key_link_clock_oe && key_link_line_oe) ? c2 + 10'h001 : 10'h000;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rlat;
    s_axil_arvalid && s_axil_arready |=> s_axil_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_bdrop;
    s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid;
  endproperty
  a_bdrop: assert property (p_bdrop) else $error("write answer repeated");
  property p_clk_low;
    !kc[2] |-> key_link_clock_oe;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock not held low");
  property p_dat_low;
    !kc[3] |-> key_link_line_oe;
  endproperty
  a_dat_low: assert property (p_dat_low) else $error("data not held low");
  property p_irq_en;
    key_irq |-> kc[4] || kc[5];
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
  property p_run;
    !kc[0] |=> !key_irq;
  endproperty
  a_run: assert property (p_run) else $error("flag kept in link reset");
  property p_req1;
    $rose(key_link_line_oe) && key_link_clock_oe && kc[3] |-> c1 == 10'(KMSC_REQ_HOLD_CYC);
  endproperty
  a_req1: assert property (p_req1) else $error("clock low phase wrong");
  property p_req2;
    $fell(key_link_clock_oe) && key_link_line_oe && kc[2] |-> c2 == 10'(KMSC_REQ_HOLD_CYC);
  endproperty
  a_req2: assert property (p_req2) else $error("start bit phase wrong");
endmodule
`default_nettype wire

// *** dv/kmsc_periph.sv ***
// behavioural keyboard or pointer device on one open-drain link
// pulls lines low only; pull-ups and wire logic live in the bench
`timescale 1ns/1ps
`default_nettype none
module kmsc_periph
(
  // link wires as seen
  input wire logic clk_w,
  input wire logic dat_w,
  // pull-downs
  output logic clk_low,
  output logic dat_low
);
  initial
  begin
    clk_low = 1'h0;
    dat_low = 1'h0;
  end
  // device to host frame; bad turns the parity bit round
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'h1, (~^b) ^ bad, b, 1'h0};
    wait (clk_w === 1'h1);
    for (int i = 0; i < 11; i++)
    begin
      dat_low = !f[i];
      #200 clk_low = 1'h1;
      #400 clk_low = 1'h0;
      #200;
    end
    dat_low = 1'h0;
  endtask
  // host to device frame; samples late in each of the first ten low phases
  task automatic recv(output logic [9:0] g);
    wait (clk_w === 1'h1 && dat_w === 1'h0);
    for (int i = 0; i < 11; i++)
    begin
      #200 clk_low = 1'h1;
      #550 if (i < 10) g[i] = dat_w;
      #50 clk_low = 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the keyboard and pointer link controller
// drives the register bus and two link devices; checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import kmsc_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axil_awaddr = 0, s_axil_wdata = 0, s_axil_araddr = 0, s_axil_rdata;
  logic [3:0] s_axil_wstrb = 0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0, s_axil_arvalid = 0, s_axil_rready = 0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic key_link_clock_i, key_link_clock_o, key_link_clock_oe, key_link_line_i, key_link_line_o, key_link_line_oe;
  logic pointer_link_clock_i, pointer_link_clock_o, pointer_link_clock_oe;
  logic pointer_link_line_i, pointer_link_line_o, pointer_link_line_oe;
  logic key_irq, pointer_irq;
  logic [1:0] cl, dl;
  int err_count = 0, checked = 0, seed = 82237, cyc = 0;
  wire [1:0] irq = {pointer_irq, key_irq};
  wire [1:0] coe = {pointer_link_clock_oe, key_link_clock_oe};
  wire [1:0] loe = {pointer_link_line_oe, key_link_line_oe};
  wire [3:0] pin_o = {key_link_clock_o, key_link_line_o, pointer_link_clock_o, pointer_link_line_o};
  always #50 aclk = ~aclk;
  // open-drain wires with pull-ups
  assign key_link_clock_i = !(key_link_clock_oe || cl[0]);
  assign key_link_line_i = !(key_link_line_oe || dl[0]);
  assign pointer_link_clock_i = !(pointer_link_clock_oe || cl[1]);
  assign pointer_link_line_i = !(pointer_link_line_oe || dl[1]);
  kmsc_top kmsc_top_inst (.*);
  kmsc_periph kmsc_periph_inst [1:0] (.clk_w({pointer_link_clock_i, key_link_clock_i}),
    .dat_w({pointer_link_line_i, key_link_line_i}), .clk_low(cl), .dat_low(dl));
  task automatic give_verdict();
    if (err_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, hb;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= {24'h00_0000, d};
    s_axil_wstrb <= 4'hf;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid <= 1'h1;
    s_axil_bready <= 1'h1;
    forever
    begin
      @(negedge aclk);
      ta = s_axil_awvalid && s_axil_awready;
      tw = s_axil_wvalid && s_axil_wready;
      hb = s_axil_bvalid && s_axil_bready;
      r = s_axil_bresp;
      @(posedge aclk);
      if (ta) s_axil_awvalid <= 1'h0;
      if (tw) s_axil_wvalid <= 1'h0;
      if (hb)
      begin
        s_axil_bready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
    logic ta, hr;
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready <= 1'h1;
    forever
    begin
      @(negedge aclk);
      ta = s_axil_arvalid && s_axil_arready;
      hr = s_axil_rvalid && s_axil_rready;
      d = s_axil_rdata[7:0];
      r = s_axil_rresp;
      @(posedge aclk);
      if (ta) s_axil_arvalid <= 1'h0;
      if (hr)
      begin
        s_axil_rready <= 1'h0;
        break;
      end
    end
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, d, e);
  endtask
  function automatic logic [31:0] ad(input int ch, input int s);
    return {KMSC_KBD_CONTROL_IDX[29:0], 2'b00} + 32'(ch * 32 + s * 8);
  endfunction
  task automatic snd(input int ch, input logic [7:0] b, input logic bad);
    if (ch == 1) kmsc_periph_inst[1].send(b, bad);
    else kmsc_periph_inst[0].send(b, bad);
  endtask
  task automatic rcv(input int ch, output logic [9:0] g);
    if (ch == 1) kmsc_periph_inst[1].recv(g);
    else kmsc_periph_inst[0].recv(g);
  endtask
  initial
  begin
    logic [7:0] b, d;
    logic [1:0] r;
    logic [9:0] g;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rd(32'h4400_1500, d, r);
    chk("unmapped read", {r, d}, {KMSC_RESP_SLVERR, 8'h00});
    wr(32'h4400_1500, 8'hff, r);
    chk("unmapped write", r, KMSC_RESP_SLVERR);
    for (int ch = 0; ch < 2; ch++)
    begin
      rchk("control reset", ad(ch, 0), 8'h00);
      rchk("status reset", ad(ch, 1), 8'h00);
      rchk("receive reset", ad(ch, 3), 8'h00);
      chk("lines held", {coe[ch], loe[ch]}, 2'h3);
      chk("pin drive", pin_o, 4'h0);
      wr(ad(ch, 0), 8'h3d, r);
      rchk("control", ad(ch, 0), 8'h3d);
      b = 8'($random(seed));
      fork
        snd(ch, b, 1'h0);
        begin
          repeat (40) @(posedge aclk);
          rchk("receiving", ad(ch, 1), 8'h01);
        end
      join
      repeat (5) @(posedge aclk);
      rchk("rx done", ad(ch, 1), 8'h04);
      rchk("rx byte", ad(ch, 3), b);
      chk("rx irq", irq[ch], 1'h1);
      chk("rx hold", coe[ch], 1'h1);
      wr(ad(ch, 1), 8'h00, r);
      repeat (2) @(posedge aclk);
      chk("released", {coe[ch], irq[ch]}, 2'h0);
      wr(ad(ch, 0), 8'h2d, r);
      b = 8'($random(seed));
      snd(ch, b, 1'h1);
      repeat (5) @(posedge aclk);
      rchk("parity error", ad(ch, 1), 8'h14);
      chk("irq masked", irq[ch], 1'h0);
      wr(ad(ch, 0), 8'h3d, r);
      if (ch == 0) wr(ad(ch, 1), 8'h00, r);
      b = 8'($random(seed));
      // parity error stays set after receive done is cleared
      rchk("idle", ad(ch, 1), ch ? 8'h14 : 8'h10);
      wr(ad(ch, 2), b, r);
      rchk("transmitting", ad(ch, 1), ch ? 8'h16 : 8'h12);
      if (ch == 1)
      begin
        repeat (600) @(posedge aclk);
        chk("send held off", loe[ch], 1'h0);
        wr(ad(ch, 1), 8'h00, r);
      end
      rcv(ch, g);
      chk("sent frame", g, {1'h1, ~^b, b});
      repeat (5) @(posedge aclk);
      rchk("tx done", ad(ch, 1), 8'h18);
      chk("tx irq", irq[ch], 1'h1);
      // keyboard aborts with tx done and its interrupt still up
      if (ch == 1)
      begin
        wr(ad(ch, 1), 8'h00, r);
        rchk("tx cleared", ad(ch, 1), 8'h10);
      end
      wr(ad(ch, 2), b, r);
      repeat (100) @(posedge aclk);
      wr(ad(ch, 0), 8'h30, r);
      rchk("aborted", ad(ch, 1), 8'h00);
      chk("abort irq", irq[ch], 1'h0);
      wr(ad(ch, 0), 8'h3d, r);
      repeat (1000) @(posedge aclk);
      chk("no resume", {coe[ch], loe[ch]}, 2'h0);
    end
    give_verdict();
  end
endmodule
bind kmsc_top kmsc_sva kmsc_sva_inst (.*);
`default_nettype wire
